// *** rtl/shift_unit_defs.vh ***
// Constants and opcode patterns for the CPU shift unit.
// Notes on behaviour
// RL1 - Dynamic arithmetic shift: left if amount non-negative, else right with sign fill.
// RL2 - Dynamic logical shift: left if amount non-negative, else right with zero fill.
// RL3 - Dynamic shift count comes only from amount bits 4 to 0.
// RL4 - Negative amount: right 1 to 32, low bits zero means 32; else left 0-31.
// RL5 - Arithmetic left one: shift left, zero in, old top bit to flag.
// RL6 - Arithmetic left one behaves exactly like logical left one.
// RL7 - Arithmetic right one: sign kept, old bottom bit to flag.
// RL8 - Logical left one: zero into bottom bit, old top bit to flag.
// RL9 - Logical right one: zero into top bit, old bottom bit to flag.
// RL10 - Fixed left shifts by 2, 8, 16 zero-fill and keep flag.
// RL11 - Fixed right shifts by 2, 8, 16 zero-fill and keep flag.
// RL12 - Each shift takes one cycle, writes back and advances PC by two.
// RL13 - Dynamic shifts keep the flag and leave the amount register alone.
`ifndef SHIFT_UNIT_DEFS_VH
`define SHIFT_UNIT_DEFS_VH
// ----------------------------------------
// Opcode fields
// ----------------------------------------
`define OP_CLASS 4'h4
`define OP_DYN_ARITH 4'hc
`define OP_DYN_LOGIC 4'hd
`define OP_LOGIC_LEFT_ONE 8'h00
`define OP_LOGIC_RIGHT_ONE 8'h01
`define OP_ARITH_LEFT_ONE 8'h20
`define OP_ARITH_RIGHT_ONE 8'h21
`define OP_LOGIC_LEFT_TWO 8'h08
`define OP_LOGIC_RIGHT_TWO 8'h09
`define OP_LOGIC_LEFT_EIGHT 8'h18
`define OP_LOGIC_RIGHT_EIGHT 8'h19
`define OP_LOGIC_LEFT_SIXTEEN 8'h28
`define OP_LOGIC_RIGHT_SIXTEEN 8'h29
`define PC_STEP 32'h00000002
`define RESET_PC 32'h00000000
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CLASS_HI 15
`define CLASS_LO 12
`define DEST_HI 11
`define DEST_LO 8
`define SUB_HI 7
`define SUB_LO 0
`define DYN_HI 3
`define DYN_LO 0
`define COUNT_HI 4
`define COUNT_LO 0
`define SIGN_BIT 31
// ----------------------------------------
// Counts and reset values
// ----------------------------------------
`define DYN_FULL_SHIFT 6'h20
`define RESET_STROBE 1'h0
`define RESET_INDEX 4'h0
`define RESET_DATA 32'h00000000
`define RESET_FLAG 1'h0
`endif

// *** rtl/barrel_shifter.v ***
// Combinational 32-bit barrel shifter used by the shift unit.
`default_nettype none
module barrel_shifter (
  input wire [31:0] data_in,   // Operand.
  input wire [5:0] amount,     // Shift distance 0 to 32.
  input wire right,            // High for a right shift.
  input wire sign_fill,        // High to fill right shifts with the sign.
  output wire [31:0] data_out  // Shifted result.
);
  wire [63:0] ext;
  wire [63:0] right_result;
  // Right shifts extend the operand to 64 bits so a distance of 32 is legal.
  assign ext = {{32{sign_fill & data_in[31]}}, data_in};
  assign right_result = ext >> amount;
  assign data_out = right ? right_result[31:0] : (data_in << amount);
endmodule
`default_nettype wire

// *** rtl/cpu_shift_unit.v ***
// Shift datapath: decodes shift opcodes and updates register, flag and PC.
`include "shift_unit_defs.vh"
`default_nettype none
module cpu_shift_unit (
  input wire clock, // Core clock.
  input wire srst, // Synchronous reset, active high.
  input wire issue, // One-cycle pulse: instruction valid.
  input wire [15:0] instr, // Instruction word.
  input wire [31:0] dest_value, // Value of destination_register.
  input wire [31:0] amount_value, // Value of amount_register.
  input wire flag_in, // Current condition flag.
  input wire [31:0] pc_in, // Address of the instruction.
  output wire wb_valid, // Write-back strobe, one cycle.
  output wire [3:0] wb_index, // Destination register index.
  output wire [31:0] wb_data, // Result to write back.
  output wire flag_out, // New condition flag.
  output wire [31:0] pc_out, // Next program counter.
  output wire illegal // Issued opcode is not a shift.
);
  // ----------------------------------------
  // Instruction fields
  // ----------------------------------------
  wire [3:0] class_field;
  wire [3:0] dest_field;
  wire [7:0] sub_field;
  wire [3:0] dyn_field;

  // Split the word into its fields once, so the decode below reads by name.
  assign class_field = instr[`CLASS_HI:`CLASS_LO];
  assign dest_field = instr[`DEST_HI:`DEST_LO];
  assign sub_field = instr[`SUB_HI:`SUB_LO];
  assign dyn_field = instr[`DYN_HI:`DYN_LO];

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  wire is_class;
  wire is_dyn_arith;
  wire is_dyn_logic;
  wire is_dyn;
  wire is_left_one;
  wire is_arith_right_one;
  wire is_logic_right_one;
  wire is_left_two;
  wire is_left_eight;
  wire is_left_sixteen;
  wire is_right_two;
  wire is_right_eight;
  wire is_right_sixteen;
  wire is_fixed;
  wire is_one_bit;
  wire is_known;
  wire accept;
  wire refuse;

  // Class 4 holds every shift of this block; the rest of the word picks one.
  assign is_class = (class_field == `OP_CLASS);
  // Dynamic shifts look at the low nibble only; bits 7 to 4 name amount_register.
  assign is_dyn_arith = (dyn_field == `OP_DYN_ARITH); // RL1
  assign is_dyn_logic = (dyn_field == `OP_DYN_LOGIC); // RL2
  assign is_dyn = is_dyn_arith | is_dyn_logic;
  // Both left-by-one codes share one match, so the two cannot drift apart.
  assign is_left_one = (sub_field == `OP_LOGIC_LEFT_ONE) |
    (sub_field == `OP_ARITH_LEFT_ONE); // RL5 RL6 RL8
  assign is_arith_right_one = (sub_field == `OP_ARITH_RIGHT_ONE); // RL7
  assign is_logic_right_one = (sub_field == `OP_LOGIC_RIGHT_ONE); // RL9
  // Fixed left distances.
  assign is_left_two = (sub_field == `OP_LOGIC_LEFT_TWO); // RL10
  assign is_left_eight = (sub_field == `OP_LOGIC_LEFT_EIGHT); // RL10
  assign is_left_sixteen = (sub_field == `OP_LOGIC_LEFT_SIXTEEN); // RL10
  // Fixed right distances.
  assign is_right_two = (sub_field == `OP_LOGIC_RIGHT_TWO); // RL11
  assign is_right_eight = (sub_field == `OP_LOGIC_RIGHT_EIGHT); // RL11
  assign is_right_sixteen = (sub_field == `OP_LOGIC_RIGHT_SIXTEEN); // RL11
  // Group the matches; no sub-field code ends in c or d, so at most one is high.
  assign is_fixed = is_left_two | is_left_eight | is_left_sixteen |
    is_right_two | is_right_eight | is_right_sixteen;
  assign is_one_bit = is_left_one | is_arith_right_one | is_logic_right_one;
  // Anything outside the shift set is refused rather than half executed.
  assign is_known = is_class & (is_dyn | is_fixed | is_one_bit);
  // An issue either writes back or is refused, never both.
  assign accept = issue & is_known; // RL12
  assign refuse = issue & ~is_known;

  // ----------------------------------------
  // Dynamic shift distance
  // ----------------------------------------
  wire [4:0] low_count;
  wire amount_neg;
  wire [5:0] count_wide;
  wire [5:0] right_count;
  wire [5:0] dyn_amount;
  wire [31:0] dyn_result;

  // Only the low five bits count; the sign bit picks the direction.
  assign low_count = amount_value[`COUNT_HI:`COUNT_LO]; // RL3
  assign amount_neg = amount_value[`SIGN_BIT]; // RL1 RL2
  // One spare bit so that a distance of 32 can be expressed.
  assign count_wide = {1'h0, low_count};
  // Negative amounts give 32 minus the low bits, so zero maps to 32.
  assign right_count = `DYN_FULL_SHIFT - count_wide; // RL4
  assign dyn_amount = amount_neg ? right_count : count_wide; // RL4

  // Shared barrel shifter; the sign fills only for the arithmetic form.
  barrel_shifter u_barrel (
    .data_in(dest_value),
    .amount(dyn_amount),
    .right(amount_neg),
    .sign_fill(is_dyn_arith), // RL1 RL2
    .data_out(dyn_result)
  );

  // ----------------------------------------
  // One-bit and fixed results
  // ----------------------------------------
  wire [31:0] left_one_result;
  wire [31:0] arith_right_one_result;
  wire [31:0] logic_right_one_result;
  wire [31:0] left_two_result;
  wire [31:0] left_eight_result;
  wire [31:0] left_sixteen_result;
  wire [31:0] right_two_result;
  wire [31:0] right_eight_result;
  wire [31:0] right_sixteen_result;
  wire top_bit;
  wire bottom_bit;

  // The bits that one-bit shifts push out into the flag.
  assign top_bit = dest_value[31];
  assign bottom_bit = dest_value[0];
  // One-bit shifts; the arithmetic right form keeps the sign in place.
  assign left_one_result = {dest_value[30:0], 1'h0}; // RL5 RL6 RL8
  assign arith_right_one_result = {dest_value[31], dest_value[31:1]}; // RL7
  assign logic_right_one_result = {1'h0, dest_value[31:1]}; // RL9
  // Fixed left shifts drop the top bits and fill zeros below.
  assign left_two_result = {dest_value[29:0], 2'h0}; // RL10
  assign left_eight_result = {dest_value[23:0], 8'h00}; // RL10
  assign left_sixteen_result = {dest_value[15:0], 16'h0000}; // RL10
  // Fixed right shifts drop the low bits and fill zeros above.
  assign right_two_result = {2'h0, dest_value[31:2]}; // RL11
  assign right_eight_result = {8'h00, dest_value[31:8]}; // RL11
  assign right_sixteen_result = {16'h0000, dest_value[31:16]}; // RL11

  // ----------------------------------------
  // Result and flag selection
  // ----------------------------------------
  reg [31:0] shift_result;
  reg shift_flag;

  // Fixed and dynamic shifts keep the flag; one-bit shifts take the bit shifted out.
  always @* begin
    shift_result = dest_value;
    shift_flag = flag_in; // RL10 RL11 RL13
    if (is_dyn) begin
      shift_result = dyn_result; // RL1 RL2 RL13
    end else if (is_left_one) begin
      shift_result = left_one_result; // RL5 RL6 RL8
      shift_flag = top_bit;
    end else if (is_arith_right_one) begin
      shift_result = arith_right_one_result; // RL7
      shift_flag = bottom_bit;
    end else if (is_logic_right_one) begin
      shift_result = logic_right_one_result; // RL9
      shift_flag = bottom_bit;
    end else if (is_left_two) begin
      shift_result = left_two_result; // RL10
    end else if (is_left_eight) begin
      shift_result = left_eight_result; // RL10
    end else if (is_left_sixteen) begin
      shift_result = left_sixteen_result; // RL10
    end else if (is_right_two) begin
      shift_result = right_two_result; // RL11
    end else if (is_right_eight) begin
      shift_result = right_eight_result; // RL11
    end else if (is_right_sixteen) begin
      shift_result = right_sixteen_result; // RL11
    end
  end

  // ----------------------------------------
  // Write-back stage
  // ----------------------------------------
  reg wb_valid_reg;
  reg [3:0] wb_index_reg;
  reg [31:0] wb_data_reg;
  reg flag_reg;
  reg [31:0] pc_reg;
  reg illegal_reg;
  reg wb_valid_next;
  reg [3:0] wb_index_next;
  reg [31:0] wb_data_next;
  reg flag_next;
  reg [31:0] pc_next;
  reg illegal_next;

  // Data outputs hold until the next accepted shift; a refused issue leaves them.
  always @* begin
    wb_valid_next = accept; // RL12
    illegal_next = refuse;
    wb_index_next = wb_index_reg;
    wb_data_next = wb_data_reg;
    flag_next = flag_reg;
    pc_next = pc_reg;
    if (accept) begin
      wb_index_next = dest_field;
      wb_data_next = shift_result; // RL12
      flag_next = shift_flag;
      pc_next = pc_in + `PC_STEP; // RL12
    end
  end

  // One issue gives one write-back a cycle later; other opcodes raise illegal.
  always @(posedge clock) begin
    if (srst) begin
      wb_valid_reg <= `RESET_STROBE;
      wb_index_reg <= `RESET_INDEX;
      wb_data_reg <= `RESET_DATA;
      flag_reg <= `RESET_FLAG;
      pc_reg <= `RESET_PC;
      illegal_reg <= `RESET_STROBE;
    end else begin
      wb_valid_reg <= wb_valid_next;
      wb_index_reg <= wb_index_next;
      wb_data_reg <= wb_data_next;
      flag_reg <= flag_next;
      pc_reg <= pc_next;
      illegal_reg <= illegal_next;
    end
  end

  // Every output comes straight from its flip-flop.
  assign wb_valid = wb_valid_reg;
  assign wb_index = wb_index_reg;
  assign wb_data = wb_data_reg;
  assign flag_out = flag_reg;
  assign pc_out = pc_reg;
  assign illegal = illegal_reg;
endmodule
`default_nettype wire

// *** bench/shift_unit_chk.sv ***
// Assertion checker for the shift unit ports.
`default_nettype none
module shift_unit_chk (
  input wire clock, srst, issue, flag_in, wb_valid, flag_out, illegal, // Control bits.
  input wire [15:0] instr, // Instruction word.
  input wire [3:0] wb_index, // Write-back index.
  input wire [31:0] dest_value, amount_value, pc_in, wb_data, pc_out // Data words.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Marks an issued opcode of the shift class.
  wire sh = issue && instr[15:12] == 4'h4;
  wire [31:0] d = dest_value;
  a_left_one: assert property (sh && instr[7:0] == 8'h00 |=> wb_data == $past(d) << 1
    && flag_out == $past(d[31])) else $error("left one wrong");
  a_arith_left_same: assert property (sh && instr[7:0] == 8'h20 |=> wb_data == $past(d) << 1
    && flag_out == $past(d[31])) else $error("arith left one wrong");
  a_arith_right_one: assert property (sh && instr[7:0] == 8'h21 |=> flag_out == $past(d[0])
    && wb_data == {$past(d[31]), $past(d[31:1])}) else $error("arith right one wrong");
  a_right_one: assert property (sh && instr[7:0] == 8'h01 |=> wb_data == $past(d) >> 1
    && flag_out == $past(d[0])) else $error("right one wrong");
  a_fixed_left_flag: assert property (sh && instr[7:0] == 8'h08 |=> wb_data == $past(d) << 2
    && flag_out == $past(flag_in)) else $error("left two wrong");
  a_fixed_right_flag: assert property (sh && instr[7:0] == 8'h19 |=> wb_data == $past(d) >> 8
    && flag_out == $past(flag_in)) else $error("right eight wrong");
  a_dyn_left_count: assert property (sh && instr[3:0] == 4'hd && !amount_value[31] |=>
    wb_data == $past(d) << $past(amount_value[4:0]) && flag_out == $past(flag_in))
    else $error("dynamic left wrong");
  a_dyn_right_sign: assert property (sh && instr[3:0] == 4'hc && amount_value[31] |=>
    $signed(wb_data) == ($signed($past(d)) >>> (6'h20 - $past(amount_value[4:0]))))
    else $error("dynamic right wrong");
  a_refused_quiet: assert property (illegal |-> !wb_valid && $stable(wb_data)
    && $stable(pc_out)) else $error("refused opcode changed outputs");
  a_pc_and_index: assert property (wb_valid |-> pc_out == $past(pc_in) + 32'h2
    && wb_index == $past(instr[11:8])) else $error("pc or index wrong");
  c_dyn_neg: cover property (sh && amount_value[31]);
  c_back_to_back: cover property (wb_valid ##1 wb_valid);
  c_refused: cover property (illegal);
endmodule
bind cpu_shift_unit shift_unit_chk chk (.clock, .srst, .issue, .flag_in, .wb_valid, .flag_out,
  .illegal, .instr, .wb_index, .dest_value, .amount_value, .pc_in, .wb_data, .pc_out);
`default_nettype wire

// *** bench/cpu_shift_unit_tb.sv ***
// Self-checking testbench for the shift unit.
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module cpu_shift_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, srst = 1, issue = 0, flag_in = 0, wb_valid, flag_out, illegal;
  logic [15:0] instr = 16'h0;
  logic [3:0] wb_index;
  logic [31:0] dest_value = 32'h0, amount_value = 32'h0, pc_in = 32'h0, wb_data, pc_out;
  int err_count = 0, checked = 0;
  cpu_shift_unit dut (.clock, .srst, .issue, .instr, .dest_value, .amount_value, .flag_in,
    .pc_in, .wb_valid, .wb_index, .wb_data, .flag_out, .pc_out, .illegal);
  // Makes the 100 MHz clock.
  initial begin forever #5 clock = ~clock; end
  // Prints the counts and the verdict, then stops.
  task tally_and_finish;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Issues one opcode; the write-back is judged one cycle later.
  task op(input logic [15:0] i, input logic [31:0] d, a, input logic f, input logic [31:0] e,
    input logic ef);
    {instr, dest_value, amount_value, flag_in, pc_in, issue} = {i, d, a, f, 16'h0, i, 1'b1};
    @(negedge clock);
    `CHK("wb_data", e, wb_data)
    `CHK("flag_out", ef, flag_out)
    `CHK("wb_valid", 1'b1, wb_valid && !illegal)
    `CHK("pc_out", {16'h0, i} + 32'h2, pc_out)
    `CHK("wb_index", i[11:8], wb_index)
  endtask
  // Back-to-back one-bit shifts with the flag taking the shifted-out bit.
  task t_one_bit;
    op(16'h4100, 32'h80000001, 32'h0, 1'b0, 32'h00000002, 1'b1);
    op(16'h4220, 32'h80000001, 32'h0, 1'b0, 32'h00000002, 1'b1);
    op(16'h4321, 32'h80000001, 32'h0, 1'b0, 32'hc0000000, 1'b1);
    op(16'h4401, 32'h80000001, 32'h0, 1'b0, 32'h40000000, 1'b1);
    issue = 0;
    @(negedge clock);
  endtask
  // Fixed shifts keep the flag.
  task t_fixed;
    op(16'h4508, 32'h12345678, 32'h0, 1'b1, 32'h48d159e0, 1'b1);
    op(16'h4618, 32'h12345678, 32'h0, 1'b1, 32'h34567800, 1'b1);
    op(16'h4728, 32'h12345678, 32'h0, 1'b1, 32'h56780000, 1'b1);
    op(16'h4809, 32'h12345678, 32'h0, 1'b1, 32'h048d159e, 1'b1);
    op(16'h4919, 32'h12345678, 32'h0, 1'b1, 32'h00123456, 1'b1);
    op(16'h4a29, 32'h12345678, 32'h0, 1'b1, 32'h00001234, 1'b1);
    issue = 0;
    @(negedge clock);
    `CHK("wb_valid", 1'b0, wb_valid)
    `CHK("wb_data", 32'h00001234, wb_data)
  endtask
  // Dynamic shifts in both directions, a count of 32 and ignored upper amount bits.
  task t_dynamic;
    op(16'h42fc, 32'h80180000, 32'hffffffec, 1'b1, 32'hfffff801, 1'b1);
    op(16'h42fd, 32'h80180000, 32'hffffffec, 1'b1, 32'h00000801, 1'b1);
    op(16'h443c, 32'hfffff801, 32'h00000014, 1'b0, 32'h80100000, 1'b0);
    op(16'h443d, 32'hfffff801, 32'h00000014, 1'b0, 32'h80100000, 1'b0);
    op(16'h4b0c, 32'h80000000, 32'hffffffe0, 1'b1, 32'hffffffff, 1'b1);
    op(16'h4b0d, 32'h80000000, 32'hffffffe0, 1'b1, 32'h00000000, 1'b1);
    op(16'h4c1d, 32'h00000001, 32'h7fffffe3, 1'b0, 32'h00000008, 1'b0);
    issue = 0;
    @(negedge clock);
  endtask
  // A rotate opcode is refused and the data outputs hold.
  task t_refused;
    instr = 16'h4104;
    issue = 1;
    @(negedge clock);
    `CHK("illegal", 1'b1, illegal && !wb_valid)
    `CHK("wb_data", 32'h00000008, wb_data)
    `CHK("pc_out", 32'h00004c1f, pc_out)
    `CHK("flag_out", 1'b0, flag_out)
    issue = 0;
  endtask
  // Main sequence after a four-cycle reset.
  initial begin
    repeat (4) @(negedge clock);
    srst = 0;
    `CHK("wb_valid", 1'b0, wb_valid)
    t_one_bit;
    t_fixed;
    t_dynamic;
    t_refused;
    tally_and_finish;
  end
  // Cuts a hang short.
  initial begin
    #5000;
    err_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
